// ==== inc/ebbc_pkg.sv ====
// ebbc_pkg: shared constants for the emulation bus and breakpoint controller
// assumes 8-bit i/o port space decoded from the low address byte
package ebbc_pkg;
	localparam logic [7:0] PORT_SVC_MAP = 8'hf3;
	localparam logic [7:0] PORT_BP1_EXT = 8'hf6;
	localparam logic [7:0] PORT_BP2_EXT = 8'hf7;
	localparam logic [7:0] PORT_DBG_CTRL = 8'hf8;
	localparam logic [7:0] PORT_DBG_CMD = 8'hf9;
	localparam logic [7:0] PORT_BP1_LO = 8'hfc;
	localparam logic [7:0] PORT_BP1_HI = 8'hfd;
	localparam logic [7:0] PORT_BP2_LO = 8'hfe;
	localparam logic [7:0] PORT_BP2_HI = 8'hff;
	localparam logic [7:0] PORT_PENDING = 8'hf2;
	// service-call window: base nibble, span of eight ports from base
	localparam logic [7:0] SVC_MAP_RESET = 8'hf0;
	localparam logic [7:0] DBG_CTRL_RESET = 8'h00;
	localparam logic [7:0] DBG_CMD_RESET = 8'h00;
	localparam int SVC_EN_BIT = 4;
	localparam int BRK_READ_BIT = 0;
	localparam int BRK_WRITE_BIT = 1;
	localparam int BP1_EN_BIT = 2;
	localparam int BP2_EN_BIT = 3;
	localparam int SVC_SPAN_BIT = 3;
	// command bits that steer ownership
	localparam int CMD_RUN_SLAVE_BIT = 0;
	localparam int CMD_DMA_BIT = 1;
	typedef enum logic [2:0] {EBBC_MASTER, EBBC_TO_SLAVE, EBBC_SLAVE, EBBC_TO_MASTER, EBBC_DMA} ebbc_own_t;
endpackage

// ==== verilog/ebbc_bp_match.sv ====
// ebbc_bp_match: one 24-bit breakpoint comparator with direction qualify
// assumes address and direction are stable in the cycle they are sampled
`timescale 1ns/1ps
module ebbc_bp_match
	import ebbc_pkg::*;
(
	// compare inputs
	input wire logic [23:0] bpAddr,
	input wire logic [23:0] busAddr,
	input wire logic busWrite,
	input wire logic brkRead,
	input wire logic brkWrite,
	// result
	output logic hit
);
	wire logic addrEq = (bpAddr == busAddr);
	wire logic dirOk = busWrite ? brkWrite : brkRead;
	assign hit = addrEq & dirOk;
endmodule

// ==== verilog/ebbc_ctrl.sv ====
// ebbc_ctrl: bus ownership, service-call detect and breakpoints for the emulator
// assumes master i/o cycles arrive as one-cycle strobes synchronous to clock
`timescale 1ns/1ps
module ebbc_ctrl
	import ebbc_pkg::*;
(
	// clock and control
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clkEn,
	// master i/o port access
	input wire logic ioStrobe,
	input wire logic ioWrite,
	input wire logic [7:0] ioAddr,
	input wire logic [7:0] ioDataIn,
	output logic [7:0] ioDataOut,
	// processor handshake
	output logic master_hold_n,
	output logic slave_hold_n,
	output logic bus_owner_flag,
	input wire logic masterHalted,
	input wire logic slaveHalted,
	input wire logic dmaRequest,
	// slave bus cycle observation
	input wire logic slave_op_request_n,
	input wire logic slaveIoSel,
	input wire logic slaveWrite,
	input wire logic [15:0] sysAddrIn,
	input wire logic [7:0] extAddrIn,
	input wire logic [1:0] emuMode,
	input wire logic service_call_mode_strap,
	input wire logic forcedJumpActive,
	input wire logic pendingClear,
	// interrupt and status
	output logic debug_irq_n,
	output logic [2:0] pendingOut
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] svcMap_reg;
	logic [7:0] svcMap_next;
	logic [7:0] dbgCtrl_reg;
	logic [7:0] dbgCtrl_next;
	logic [7:0] dbgCmd_reg;
	logic [7:0] dbgCmd_next;
	logic [23:0] bp1_reg;
	logic [23:0] bp1_next;
	logic [23:0] bp2_reg;
	logic [23:0] bp2_next;
	ebbc_own_t own_reg;
	ebbc_own_t own_next;
	logic svcPend_reg;
	logic svcPend_next;
	logic bp1Pend_reg;
	logic bp1Pend_next;
	logic bp2Pend_reg;
	logic bp2Pend_next;
	logic [7:0] dataOut_reg;
	logic [7:0] dataOut_next;
	logic mHold_reg;
	logic mHold_next;
	logic sHold_reg;
	logic sHold_next;
	logic owner_reg;
	logic owner_next;
	logic irqN_reg;
	logic irqN_next;

	function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] lane, input logic [7:0] b);
		logic [23:0] r;
		r = v;
		case (lane)
			2'd0: r[7:0] = b;
			2'd1: r[15:8] = b;
			default: r[23:16] = b;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// port decode, inbound data path only on writes
	wire logic wrStb = ioStrobe & ioWrite;
	wire logic rdStb = ioStrobe & ~ioWrite;
	wire logic wrMap = wrStb & (ioAddr == PORT_SVC_MAP);
	wire logic wrCtrl = wrStb & (ioAddr == PORT_DBG_CTRL);
	wire logic wrCmd = wrStb & (ioAddr == PORT_DBG_CMD);
	wire logic wrBp1Lo = wrStb & (ioAddr == PORT_BP1_LO);
	wire logic wrBp1Hi = wrStb & (ioAddr == PORT_BP1_HI);
	wire logic wrBp1Ex = wrStb & (ioAddr == PORT_BP1_EXT);
	wire logic wrBp2Lo = wrStb & (ioAddr == PORT_BP2_LO);
	wire logic wrBp2Hi = wrStb & (ioAddr == PORT_BP2_HI);
	wire logic wrBp2Ex = wrStb & (ioAddr == PORT_BP2_EXT);
	wire logic rdPend = rdStb & (ioAddr == PORT_PENDING);

	assign svcMap_next = wrMap ? ioDataIn : svcMap_reg;
	assign dbgCtrl_next = wrCtrl ? ioDataIn : dbgCtrl_reg;
	assign dbgCmd_next = wrCmd ? ioDataIn : dbgCmd_reg;
	wire logic [23:0] bp1a = wrBp1Lo ? put_byte(bp1_reg, 2'd0, ioDataIn) : bp1_reg;
	wire logic [23:0] bp1b = wrBp1Hi ? put_byte(bp1a, 2'd1, ioDataIn) : bp1a;
	assign bp1_next = wrBp1Ex ? put_byte(bp1b, 2'd2, ioDataIn) : bp1b;
	wire logic [23:0] bp2a = wrBp2Lo ? put_byte(bp2_reg, 2'd0, ioDataIn) : bp2_reg;
	wire logic [23:0] bp2b = wrBp2Hi ? put_byte(bp2a, 2'd1, ioDataIn) : bp2a;
	assign bp2_next = wrBp2Ex ? put_byte(bp2b, 2'd2, ioDataIn) : bp2b;

	// outbound data path: pending flags readable, other ports write-only
	assign dataOut_next = rdPend ? {5'h00, bp2Pend_reg, bp1Pend_reg, svcPend_reg} : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// ownership sequencer
	wire logic wantSlave = dbgCmd_reg[CMD_RUN_SLAVE_BIT];
	wire logic wantDma = dbgCmd_reg[CMD_DMA_BIT] | dmaRequest;
	// master wins whenever software withdraws the slave or an irq is raised, unless dma is wanted, which then takes the bus
	wire logic masterWants = ~wantSlave | ~debug_irq_n;

	always_comb begin
		own_next = own_reg;
		case (own_reg)
			EBBC_MASTER: begin
				if (wantDma)
					own_next = EBBC_TO_MASTER;
				else if (~masterWants)
					own_next = EBBC_TO_SLAVE;
			end
			EBBC_TO_SLAVE: begin
				if (masterHalted)
					own_next = EBBC_SLAVE;
			end
			EBBC_SLAVE: begin
				if (masterWants | wantDma)
					own_next = EBBC_TO_MASTER;
			end
			EBBC_TO_MASTER: begin
				if (masterHalted & slaveHalted)
					own_next = wantDma ? EBBC_DMA : EBBC_MASTER;
			end
			EBBC_DMA: begin
				if (~wantDma)
					own_next = EBBC_MASTER;
			end
			default: own_next = EBBC_MASTER;
		endcase
	end

	// both holds during handover keep buses idle while the owner drains
	always_comb begin
		case (own_next)
			EBBC_MASTER: begin
				mHold_next = 1'b1;
				sHold_next = 1'b0;
			end
			EBBC_SLAVE: begin
				mHold_next = 1'b0;
				sHold_next = 1'b1;
			end
			default: begin
				mHold_next = 1'b0;
				sHold_next = 1'b0;
			end
		endcase
	end
	// mHold_next high means master runs; outputs are active-low holds
	// flag stays with the slave until it has really stopped
	assign owner_next = (own_next == EBBC_SLAVE) | (owner_reg & ~slaveHalted);

	////////////////////////////////////////////////////////////////////////
	// service-call detection: slave i/o read/write in window
	wire logic svcModeOk = (emuMode > 2'd1) | service_call_mode_strap;
	wire logic svcEnabled = dbgCmd_reg[SVC_EN_BIT] & svcModeOk;
	wire logic inWindow = (sysAddrIn[7:4] == svcMap_reg[7:4]) & ~sysAddrIn[SVC_SPAN_BIT];
	wire logic slaveCycle = ~slave_op_request_n & owner_reg;
	wire logic svcHit = slaveCycle & slaveIoSel & inWindow & svcEnabled;

	////////////////////////////////////////////////////////////////////////
	// breakpoints
	wire logic [23:0] fullAddr = {extAddrIn, sysAddrIn};
	wire logic hit1, hit2;
	wire logic anyPend = svcPend_reg | bp1Pend_reg | bp2Pend_reg;
	wire logic bpQual = slaveCycle & ~slaveIoSel & ~anyPend & ~forcedJumpActive;

	ebbc_bp_match uBp1 (
		.bpAddr(bp1_reg),
		.busAddr(fullAddr),
		.busWrite(slaveWrite),
		.brkRead(dbgCtrl_reg[BRK_READ_BIT]),
		.brkWrite(dbgCtrl_reg[BRK_WRITE_BIT]),
		.hit(hit1)
	);
	ebbc_bp_match uBp2 (
		.bpAddr(bp2_reg),
		.busAddr(fullAddr),
		.busWrite(slaveWrite),
		.brkRead(dbgCtrl_reg[BRK_READ_BIT]),
		.brkWrite(dbgCtrl_reg[BRK_WRITE_BIT]),
		.hit(hit2)
	);

	wire logic bp1Fire = bpQual & hit1 & dbgCtrl_reg[BP1_EN_BIT];
	wire logic bp2Fire = bpQual & hit2 & dbgCtrl_reg[BP2_EN_BIT];

	// set wins over clear so a coincident event is not lost
	assign svcPend_next = svcHit | (svcPend_reg & ~pendingClear);
	assign bp1Pend_next = bp1Fire | (bp1Pend_reg & ~pendingClear);
	assign bp2Pend_next = bp2Fire | (bp2Pend_reg & ~pendingClear);
	assign irqN_next = ~(svcPend_next | bp1Pend_next | bp2Pend_next);

	////////////////////////////////////////////////////////////////////////
	// state
	// window map returns to its default on every restart
	always_ff @(posedge clock) begin
		if (!rst_b)
			svcMap_reg <= SVC_MAP_RESET;
		else if (clkEn)
			svcMap_reg <= svcMap_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			dbgCtrl_reg <= DBG_CTRL_RESET;
		else if (clkEn)
			dbgCtrl_reg <= dbgCtrl_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			dbgCmd_reg <= DBG_CMD_RESET;
		else if (clkEn)
			dbgCmd_reg <= dbgCmd_next;
	end

	// breakpoints stay disarmed through the enable bits, not the address
	always_ff @(posedge clock) begin
		if (!rst_b)
			bp1_reg <= 24'h000000;
		else if (clkEn)
			bp1_reg <= bp1_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			bp2_reg <= 24'h000000;
		else if (clkEn)
			bp2_reg <= bp2_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			own_reg <= EBBC_MASTER;
		else if (clkEn)
			own_reg <= own_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			svcPend_reg <= 1'b0;
		else if (clkEn)
			svcPend_reg <= svcPend_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			bp1Pend_reg <= 1'b0;
		else if (clkEn)
			bp1Pend_reg <= bp1Pend_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			bp2Pend_reg <= 1'b0;
		else if (clkEn)
			bp2Pend_reg <= bp2Pend_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			dataOut_reg <= 8'h00;
		else if (clkEn)
			dataOut_reg <= dataOut_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			mHold_reg <= 1'b1;
		else if (clkEn)
			mHold_reg <= mHold_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			sHold_reg <= 1'b0;
		else if (clkEn)
			sHold_reg <= sHold_next;
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			owner_reg <= 1'b0;
		else if (clkEn)
			owner_reg <= owner_next;
	end

	// irq built from the next flags so pin and flags move together
	always_ff @(posedge clock) begin
		if (!rst_b)
			irqN_reg <= 1'b1;
		else if (clkEn)
			irqN_reg <= irqN_next;
	end

	// hold pins active low: pin low while that processor must pause
	assign master_hold_n = mHold_reg;
	assign slave_hold_n = sHold_reg;
	assign bus_owner_flag = owner_reg;
	assign debug_irq_n = irqN_reg;
	assign pendingOut = {bp2Pend_reg, bp1Pend_reg, svcPend_reg};
	assign ioDataOut = dataOut_reg;
endmodule

// ==== bench/ebbc_ctrl_assertions.sv ====
// ebbc_ctrl_assertions: concurrent checks on the controller's ports
// assumes bind from the testbench top, single clock domain
`timescale 1ns/1ps
module ebbc_ctrl_assertions (
	// clock and io
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic ioStrobe,
	input wire logic ioWrite,
	input wire logic [7:0] ioAddr,
	input wire logic [7:0] ioDataOut,
	// handshake and slave bus
	input wire logic master_hold_n,
	input wire logic slave_hold_n,
	input wire logic bus_owner_flag,
	input wire logic masterHalted,
	input wire logic slaveHalted,
	input wire logic dmaRequest,
	input wire logic slave_op_request_n,
	input wire logic slaveIoSel,
	input wire logic forcedJumpActive,
	input wire logic debug_irq_n,
	input wire logic [2:0] pendingOut
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	sequence s_flagRead;
		clkEn && ioStrobe && !ioWrite && ioAddr == 8'hf2;
	endsequence
	sequence s_dmaHeld;
		(dmaRequest && clkEn)[*6];
	endsequence
	property p_oneHold; !(master_hold_n && slave_hold_n); endproperty
	property p_owner; bus_owner_flag |-> !master_hold_n; endproperty
	property p_slaveRun; slave_hold_n |-> bus_owner_flag && !master_hold_n; endproperty
	property p_rst; $rose(rst_b) |-> master_hold_n && !slave_hold_n && !bus_owner_flag; endproperty
	property p_toSlave; $rose(bus_owner_flag) |-> $past(masterHalted); endproperty
	property p_toMaster; $fell(bus_owner_flag) |-> $past(slaveHalted); endproperty
	property p_dma; s_dmaHeld |-> !master_hold_n && !slave_hold_n; endproperty
	property p_irq; (pendingOut != 3'h0) == !debug_irq_n; endproperty
	property p_read; s_flagRead |=> ioDataOut == {5'h00, $past(pendingOut)}; endproperty
	property p_bpMem; $rose(|pendingOut[2:1]) |-> $past(!slave_op_request_n && !slaveIoSel && bus_owner_flag); endproperty
	property p_bpQual; $rose(|pendingOut[2:1]) |-> $past(!forcedJumpActive && debug_irq_n); endproperty
	property p_svc; $rose(pendingOut[0]) |-> $past(slaveIoSel && !slave_op_request_n && bus_owner_flag); endproperty
	////////////////////////////////////////////////////////////////
	a_oneHold: assert property (p_oneHold) else $error("both holds released");
	a_owner: assert property (p_owner) else $error("owner flag and holds disagree");
	a_slaveRun: assert property (p_slaveRun) else $error("slave released without owning");
	a_rst: assert property (p_rst) else $error("wrong state after reset");
	a_toSlave: assert property (p_toSlave) else $error("slave granted before master halted");
	a_toMaster: assert property (p_toMaster) else $error("master granted before slave halted");
	a_dma: assert property (p_dma) else $error("dma without both holds");
	a_irq: assert property (p_irq) else $error("irq line disagrees with flags");
	a_read: assert property (p_read) else $error("flag read wrong");
	a_bpMem: assert property (p_bpMem) else $error("break outside slave memory cycle");
	a_bpQual: assert property (p_bpQual) else $error("break not suppressed");
	a_svc: assert property (p_svc) else $error("service flag without slave io cycle");
endmodule

// ==== bench/ebbc_proc_model.sv ====
// ebbc_proc_model: processor that halts some cycles after its hold drops
// assumes hold is active low and sampled on the rising clock
`timescale 1ns/1ps
module ebbc_proc_model #(
	parameter int DLY = 1
) (
	input wire logic clock,
	input wire logic hold_n,
	output logic halted
);
	logic [3:0] stopPipe = 4'h0;
	// halt lags the hold by DLY cycles; slow instances stress handover
	always @(posedge clock) stopPipe <= {stopPipe[2:0], !hold_n};
	assign halted = stopPipe[DLY-1];
endmodule

// ==== bench/test_ebbc_ctrl.sv ====
// test_ebbc_ctrl: random plus corner tests of ownership, service calls, breakpoints
// assumes ebbc_pkg compiled first; bench stands in for the slave bus
`timescale 1ns/1ps
module test_ebbc_ctrl;
	logic clock = 0, rst_b = 0, clkEn = 1, ioStrobe = 0, ioWrite = 0, dmaRequest = 0;
	logic slave_op_request_n = 1, slaveIoSel = 0, slaveWrite = 0, strap = 0, fj = 0, pendingClear = 0;
	logic masterHalted, slaveHalted, master_hold_n, slave_hold_n, bus_owner_flag, debug_irq_n;
	logic [7:0] ioAddr = 8'h00, ioDataIn = 8'h00, ioDataOut, extAddrIn = 8'h00, base;
	logic [15:0] sysAddrIn = 16'h0000;
	logic [1:0] emuMode = 2'h2;
	logic [2:0] pendingOut;
	logic [23:0] a;
	int mismatches = 0, n_checks = 0;
	initial forever #5 clock = ~clock;
	////////////////////////////////////////////////////////////////
	ebbc_ctrl u_ebbc_ctrl (.clock, .rst_b, .clkEn, .ioStrobe, .ioWrite, .ioAddr, .ioDataIn, .ioDataOut,
		.master_hold_n, .slave_hold_n, .bus_owner_flag, .masterHalted, .slaveHalted, .dmaRequest,
		.slave_op_request_n, .slaveIoSel, .slaveWrite, .sysAddrIn, .extAddrIn, .emuMode,
		.service_call_mode_strap(strap), .forcedJumpActive(fj), .pendingClear, .debug_irq_n, .pendingOut);
	ebbc_proc_model #(.DLY(1)) u_mst (.clock, .hold_n(master_hold_n), .halted(masterHalted));
	ebbc_proc_model #(.DLY(3)) u_slv (.clock, .hold_n(slave_hold_n), .halted(slaveHalted));
	////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [23:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] ad, d);
		@(negedge clock); ioStrobe = 1; ioWrite = 1; ioAddr = ad; ioDataIn = d;
		@(negedge clock); ioStrobe = 0;
	endtask
	task rd(input logic [7:0] ad, exp);
		@(negedge clock); ioStrobe = 1; ioWrite = 0; ioAddr = ad;
		@(negedge clock); ioStrobe = 0; chk(ioDataOut, exp);
	endtask
	// slave cycle once the slave owns; bus inverts when released
	task slv(input logic io, w, input logic [23:0] ad, input logic [2:0] e);
		for (int i = 0; i < 40 && bus_owner_flag !== 1'b1; i++) @(negedge clock);
		if (bus_owner_flag !== 1'b1) begin mismatches++; results; end
		@(negedge clock); slave_op_request_n = 0; slaveIoSel = io; slaveWrite = w; {extAddrIn, sysAddrIn} = ad;
		@(negedge clock); slave_op_request_n = 1; {extAddrIn, sysAddrIn} = ~ad;
		@(negedge clock); chk(pendingOut, e);
		rd(8'hf2, {5'h00, e});
		pendingClear = 1; @(negedge clock); pendingClear = 0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(44857));
		repeat (3) @(negedge clock);
		rst_b = 1;
		chk({master_hold_n, slave_hold_n, bus_owner_flag}, 3'b100);
		rd(8'hf2, 8'h00);
		wr(8'hf9, 8'h11);
		slv(1, 0, 24'h0000f5, 3'b001);
		slv(1, 0, 24'h0000f8, 3'b000);
		base = {4'($urandom % 16), 4'h0};
		wr(8'hf3, base);
		slv(1, 0, {16'h0000, base | 8'($urandom % 8)}, 3'b001);
		emuMode = 2'h0;
		slv(1, 0, {16'h0000, base}, 3'b000);
		strap = 1;
		slv(1, 0, {16'h0000, base}, 3'b001);
		emuMode = 2'h3;
		wr(8'hf9, 8'h01);
		slv(1, 0, {16'h0000, base}, 3'b000);
		$display("service call test done");
		for (int i = 0; i < 2; i++) begin
			a = (i == 0) ? 24'hffffff : 24'($urandom);
			wr(8'hfc + 8'(2 * i), a[7:0]);
			wr(8'hfd + 8'(2 * i), a[15:8]);
			wr(8'hf6 + 8'(i), a[23:16]);
			wr(8'hf8, 8'h01 | (8'h04 << i));
			slv(0, 0, a, 3'b010 << i);
			slv(0, 1, a, 3'b000);
			slv(1, 0, a, 3'b000);
			slv(0, 0, a ^ 24'h800000, 3'b000);
			fj = 1;
			slv(0, 0, a, 3'b000);
			fj = 0;
			wr(8'hf8, 8'h02 | (8'h04 << i));
			slv(0, 1, a, 3'b010 << i);
		end
		$display("breakpoint test done");
		dmaRequest = 1;
		repeat (10) @(negedge clock);
		chk({master_hold_n, slave_hold_n}, 2'b00);
		dmaRequest = 0;
		$display("dma test done");
		results;
	end
endmodule
bind ebbc_ctrl ebbc_ctrl_assertions u_ebbc_ctrl_assertions (.clock, .rst_b, .clkEn, .ioStrobe, .ioWrite,
	.ioAddr, .ioDataOut, .master_hold_n, .slave_hold_n, .bus_owner_flag, .masterHalted, .slaveHalted,
	.dmaRequest, .slave_op_request_n, .slaveIoSel, .forcedJumpActive, .debug_irq_n, .pendingOut);
